//--- design/smart_attr_pkg.sv
// constants for the health-attribute sector builder
package smart_attr_pkg;
   // task-file command signature
   localparam logic [7:0] CMD_SMART        = 8'hB0;
   localparam logic [7:0] FEAT_READ_THR    = 8'hD1;
   localparam logic [7:0] FEAT_STATUS      = 8'hDA;
   localparam logic [7:0] SIG_CYL_LO       = 8'h4F;
   localparam logic [7:0] SIG_CYL_HI       = 8'hC2;
   localparam logic [2:0] DH_UPPER         = 3'b111;
   localparam logic [7:0] EXCEED_CYL_LO    = 8'hF4;
   localparam logic [7:0] EXCEED_CYL_HI    = 8'h2C;
   // attribute identifiers and fields
   localparam logic [7:0] ID_SPARE         = 8'hC4;
   localparam logic [7:0] ID_ERASE         = 8'hE5;
   localparam logic [7:0] ID_ECC_TOTAL     = 8'hCB;
   localparam logic [7:0] ID_ECC_CORR      = 8'hCC;
   localparam logic [7:0] ID_READS         = 8'hE8;
   localparam logic [7:0] ID_CRC           = 8'hC7;
   localparam logic [15:0] FLAGS_ADVISORY  = 16'h0002;
   localparam logic [7:0] FIXED_VALUE      = 8'h64;
   localparam logic [6:0] FULL_PERCENT     = 7'h64;
   // attribute selector codes on the read port
   localparam logic [2:0] SEL_ERASE        = 3'h0;
   localparam logic [2:0] SEL_ECC_TOTAL    = 3'h1;
   localparam logic [2:0] SEL_ECC_CORR     = 3'h2;
   localparam logic [2:0] SEL_READS        = 3'h3;
   localparam logic [2:0] SEL_CRC          = 3'h4;
   // threshold sector layout
   localparam logic [15:0] THR_VERSION     = 16'h0004;
   localparam logic [8:0] ENTRY_BASE       = 9'h002;
   localparam logic [3:0] ENTRY_BYTES      = 4'hC;
   localparam logic [8:0] LAST_BYTE        = 9'h1FF;
   localparam int         NUM_THR_ENTRIES  = 6;
   // reset values
   localparam logic [7:0] THR_RESET        = 8'h00;
   localparam logic [7:0] LIFE_RESET       = 8'h64;
endpackage : smart_attr_pkg

//--- design/smart_attribute_sector_builder.sv
// health-attribute entries, status query and threshold sector streamer
// How it works
// - erase entry has id E5h and flag word 0002h.
// - erase entry byte 3 is remaining life percent from erases versus budget.
// - erase entry bytes 4-11 hold the total erase count.
// - threshold exceeded when erase life value is below erase threshold.
// - total ECC entry CBh, value 64h, bytes 4-7 all ECC errors.
// - correctable ECC entry CCh, value 64h, bytes 4-7 correctable errors.
// - read entry E8h, value 64h, bytes 4-11 flash read count.
// - CRC entry C7h, value 64h, bytes 4-7 interface CRC errors.
// - error, read and CRC entries never cause threshold exceeded.
// - threshold read returns exactly one 512-byte sector.
// - sector starts with version 0004h, then 12-byte threshold entries.
// - spare entry has C4h then spare threshold, rest zero.
// - erase entry has E5h then erase threshold, rest zero.
// - total and correctable ECC threshold entries carry zero threshold.
// - multi-byte fields go least significant byte first.
// - status query answers F4h/2Ch when exceeded, else 4Fh/C2h.
module smart_attribute_sector_builder (
   // clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // task-file command from the host controller
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [7:0]  cmd_features,
   input  wire logic [7:0]  cmd_cyl_lo,
   input  wire logic [7:0]  cmd_cyl_hi,
   input  wire logic [7:0]  cmd_drive_head,
   output logic             cmd_reject,
   output logic             busy,
   // status query answer
   output logic             status_valid,
   output logic [7:0]       status_cyl_lo,
   output logic [7:0]       status_cyl_hi,
   // drive event counters and settings
   input  wire logic        erase_evt,
   input  wire logic        read_evt,
   input  wire logic        ecc_corr_evt,
   input  wire logic        ecc_uncorr_evt,
   input  wire logic        crc_evt,
   input  wire logic [31:0] erase_budget,
   input  wire logic [7:0]  erase_thr,
   input  wire logic [7:0]  spare_thr,
   input  wire logic [7:0]  spare_value,
   // attribute entry byte port
   input  wire logic [2:0]  attr_sel,
   input  wire logic [3:0]  attr_idx,
   output logic [7:0]       attr_byte,
   // threshold sector byte stream
   output logic             sector_valid,
   output logic [7:0]       sector_data,
   output logic             sector_last,
   input  wire logic        sector_ready
);
   import smart_attr_pkg::*;

   // one-hot states: idle waits for commands, stream feeds the buffer
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b01,
      ST_STREAM = 2'b10
   } stream_e;

   stream_e     state;
   logic [63:0] erase_cnt;
   logic [63:0] read_cnt;
   logic [31:0] ecc_total_cnt;
   logic [31:0] ecc_corr_cnt;
   logic [31:0] crc_cnt;
   logic [71:0] life_acc;
   logic [6:0]  life_used;
   logic [7:0]  life_pct;
   logic [8:0]  src_idx;
   logic [7:0]  chk_sum;
   logic        skid_valid;
   logic [7:0]  skid_data;
   logic        skid_last;
   logic        push;
   logic        pop;
   logic [7:0]  src_byte;
   logic [71:0] erase_scaled;
   logic [71:0] next_life_acc;
   logic        sig_ok;
   logic        exceeded;

   // pick byte n of a 64-bit little-endian field
   function automatic logic [7:0] le_byte(input logic [63:0] v, input logic [3:0] n);
      le_byte = v[n[2:0]*8 +: 8];
   endfunction

   // one 12-byte attribute entry with advisory flags
   function automatic logic [7:0] attr_entry(input logic [7:0] id, input logic [7:0] val,
                                             input logic [63:0] raw, input logic [3:0] n);
      case (n)
         4'h0:    attr_entry = id;
         4'h1:    attr_entry = FLAGS_ADVISORY[7:0];
         4'h2:    attr_entry = FLAGS_ADVISORY[15:8];
         4'h3:    attr_entry = val;
         default: attr_entry = le_byte(raw, n - 4'h4);
      endcase
   endfunction

   // one 12-byte threshold entry: id, threshold, zeros
   function automatic logic [7:0] thr_entry(input logic [7:0] id, input logic [7:0] thr,
                                            input logic [3:0] n);
      case (n)
         4'h0:    thr_entry = id;
         4'h1:    thr_entry = thr;
         default: thr_entry = 8'h00;
      endcase
   endfunction

   // threshold sector content for one byte position, checksum excluded
   function automatic logic [7:0] sector_byte(input logic [8:0] idx, input logic [7:0] e_thr,
                                              input logic [7:0] s_thr);
      logic [8:0] rel;
      logic [8:0] ent;
      logic [3:0] off;
      // entry number kept at full width: a 4-bit copy would wrap every 192
      // bytes and echo the table into the reserved area
      rel = idx - ENTRY_BASE;
      ent = rel / 9'(ENTRY_BYTES);
      off = 4'(rel % 9'(ENTRY_BYTES));
      sector_byte = 8'h00;
      if (idx == 9'h000) begin
         sector_byte = THR_VERSION[7:0];
      end else if (idx == 9'h001) begin
         sector_byte = THR_VERSION[15:8];
      end else if (idx >= ENTRY_BASE && ent < 9'(NUM_THR_ENTRIES)) begin
         case (ent)
            9'h000:  sector_byte = thr_entry(ID_SPARE, s_thr, off);
            9'h001:  sector_byte = thr_entry(ID_ERASE, e_thr, off);
            9'h002:  sector_byte = thr_entry(ID_ECC_TOTAL, 8'h00, off);
            9'h003:  sector_byte = thr_entry(ID_ECC_CORR, 8'h00, off);
            9'h004:  sector_byte = thr_entry(ID_READS, 8'h00, off);
            default: sector_byte = thr_entry(ID_CRC, 8'h00, off);
         endcase
      end
   endfunction

   // signature check and threshold decision
   assign sig_ok = cmd_code == CMD_SMART && cmd_cyl_lo == SIG_CYL_LO
                   && cmd_cyl_hi == SIG_CYL_HI
                   && cmd_drive_head[7:5] == DH_UPPER;
   // only spare and erase life take part; counters never do
   assign exceeded = (life_pct < erase_thr) || (spare_value < spare_thr);

   // stream source: last byte is the two's complement of the running sum
   assign src_byte = (src_idx == LAST_BYTE) ? 8'(8'h00 - chk_sum)
                                            : sector_byte(src_idx, erase_thr, spare_thr);
   // fetch only into a free skid slot, so a stalled receiver never loses a byte
   assign push = ce && state == ST_STREAM && !skid_valid;
   assign pop  = ce && sector_valid && sector_ready;

   // command decode and sector sequencing
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state         <= ST_IDLE;
         busy          <= 1'b0;
         cmd_reject    <= 1'b0;
         status_valid  <= 1'b0;
         status_cyl_lo <= SIG_CYL_LO;
         status_cyl_hi <= SIG_CYL_HI;
      end else if (ce) begin
         // answer pulses last one cycle unless set again below
         cmd_reject   <= 1'b0;
         status_valid <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (cmd_valid) begin
                  // the tail of a sector may still drain after the state returns
                  // to idle; busy keeps new work out until it has gone
                  if (sig_ok && cmd_features == FEAT_READ_THR && !busy) begin
                     state <= ST_STREAM;
                     busy  <= 1'b1;
                  end else if (sig_ok && cmd_features == FEAT_STATUS && !busy) begin
                     status_valid  <= 1'b1;
                     status_cyl_lo <= exceeded ? EXCEED_CYL_LO : SIG_CYL_LO;
                     status_cyl_hi <= exceeded ? EXCEED_CYL_HI : SIG_CYL_HI;
                  end else begin
                     cmd_reject <= 1'b1;
                  end
               end
            end
            ST_STREAM: begin
               // commands during a transfer are refused rather than queued
               if (cmd_valid) begin
                  cmd_reject <= 1'b1;
               end
               if (push && src_idx == LAST_BYTE) begin
                  state <= ST_IDLE;
               end
               if (sector_last && pop && !skid_valid) begin
                  busy <= 1'b0;
               end
            end
            default: begin
               // an illegal state code falls back to idle
               state <= ST_IDLE;
               busy  <= 1'b0;
            end
         endcase
         // busy drops once the final byte leaves the buffer
         if (state == ST_IDLE && busy && sector_last && pop && !skid_valid) begin
            busy <= 1'b0;
         end
      end
   end

   // byte index and checksum accumulation
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         src_idx <= 9'h000;
         chk_sum <= 8'h00;
      end else if (ce) begin
         // idle rewinds both, so each sector starts at byte 0 with a clean sum
         if (state == ST_IDLE) begin
            src_idx <= 9'h000;
            chk_sum <= 8'h00;
         end else if (push) begin
            src_idx <= src_idx + 9'h001;
            chk_sum <= chk_sum + src_byte;
         end
      end
   end

   // two-entry buffer: output stage plus skid, so a stall loses no byte
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sector_valid <= 1'b0;
         sector_data  <= 8'h00;
         sector_last  <= 1'b0;
         skid_valid   <= 1'b0;
         skid_data    <= 8'h00;
         skid_last    <= 1'b0;
      end else if (ce) begin
         // the output stage refills first, from the skid slot if it holds a byte
         if (!sector_valid || pop) begin
            if (skid_valid) begin
               sector_valid <= 1'b1;
               sector_data  <= skid_data;
               sector_last  <= skid_last;
               skid_valid   <= push;
               skid_data    <= src_byte;
               skid_last    <= src_idx == LAST_BYTE;
            end else begin
               sector_valid <= push;
               sector_data  <= push ? src_byte : 8'h00;
               sector_last  <= push && src_idx == LAST_BYTE;
            end
         end else if (push) begin
            skid_valid <= 1'b1; // output held: park the byte
            skid_data  <= src_byte;
            skid_last  <= src_idx == LAST_BYTE;
         end
      end
   end

   // event counters; they wrap, which takes far longer than a drive lives
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         erase_cnt     <= 64'h0;
         read_cnt      <= 64'h0;
         ecc_total_cnt <= 32'h0;
         ecc_corr_cnt  <= 32'h0;
         crc_cnt       <= 32'h0;
      end else if (ce) begin
         if (erase_evt) begin
            erase_cnt <= erase_cnt + 64'h1;
         end
         if (read_evt) begin
            read_cnt <= read_cnt + 64'h1;
         end
         // both kinds in one cycle are two errors, so each adds its own one
         if (ecc_corr_evt || ecc_uncorr_evt) begin
            ecc_total_cnt <= ecc_total_cnt + {31'h0, ecc_corr_evt}
                             + {31'h0, ecc_uncorr_evt};
         end
         if (ecc_corr_evt) begin
            ecc_corr_cnt <= ecc_corr_cnt + 32'h1;
         end
         if (crc_evt) begin
            crc_cnt <= crc_cnt + 32'h1;
         end
      end
   end

   // life estimate by repeated addition: one percent step per cycle,
   // avoiding a wide divider at the cost of up to 101 cycles of lag
   assign erase_scaled  = {8'h00, erase_cnt} * 72'(FULL_PERCENT);
   assign next_life_acc = life_acc + {40'h0, erase_budget};

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         life_acc  <= 72'h0;
         life_used <= 7'h00;
         life_pct  <= LIFE_RESET;
      end else if (ce) begin
         // a zero budget means no target is known; life then stays at full
         if (erase_budget != 32'h0 && life_used < FULL_PERCENT
             && next_life_acc <= erase_scaled) begin
            life_acc  <= next_life_acc;
            life_used <= life_used + 7'h01;
         end else begin
            // loop ended: publish the result and start over from zero
            life_pct  <= {1'b0, FULL_PERCENT - life_used};
            life_acc  <= 72'h0;
            life_used <= 7'h00;
         end
      end
   end

   // attribute entry byte port, one cycle after the select
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         attr_byte <= 8'h00;
      end else if (ce) begin
         // positions past the 12-byte entry read as zero rather than wrapping
         if (attr_idx >= ENTRY_BYTES) begin
            attr_byte <= 8'h00;
         end else begin
            case (attr_sel)
               SEL_ERASE:     attr_byte <= attr_entry(ID_ERASE, life_pct, erase_cnt,
                                                      attr_idx);
               SEL_ECC_TOTAL: attr_byte <= attr_entry(ID_ECC_TOTAL, FIXED_VALUE,
                                                      {32'h0, ecc_total_cnt}, attr_idx);
               SEL_ECC_CORR:  attr_byte <= attr_entry(ID_ECC_CORR, FIXED_VALUE,
                                                      {32'h0, ecc_corr_cnt}, attr_idx);
               SEL_READS:     attr_byte <= attr_entry(ID_READS, FIXED_VALUE, read_cnt,
                                                      attr_idx);
               SEL_CRC:       attr_byte <= attr_entry(ID_CRC, FIXED_VALUE,
                                                      {32'h0, crc_cnt}, attr_idx);
               default:       attr_byte <= 8'h00;
            endcase
         end
      end
   end

endmodule // smart_attribute_sector_builder

//--- verif/sasb_props.sv
// assertions on the attribute sector builder ports
module sasb_checker
   import smart_attr_pkg::*;
(
   // clock and command side
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       ce,
   input wire logic       cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_features,
   input wire logic [7:0] cmd_cyl_lo,
   input wire logic [7:0] cmd_cyl_hi,
   input wire logic [7:0] cmd_drive_head,
   // answers
   input wire logic       cmd_reject,
   input wire logic       busy,
   input wire logic       status_valid,
   input wire logic [7:0] status_cyl_lo,
   input wire logic [7:0] status_cyl_hi,
   // sector stream
   input wire logic       sector_valid,
   input wire logic [7:0] sector_data,
   input wire logic       sector_last,
   input wire logic       sector_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic       take;
   logic       sig_ok;
   logic       pop;
   logic [8:0] pops;
   // command qualifiers and byte transfers
   assign take   = cmd_valid && ce;
   assign sig_ok = cmd_code == CMD_SMART && cmd_cyl_lo == SIG_CYL_LO
                   && cmd_cyl_hi == SIG_CYL_HI && cmd_drive_head[7:5] == DH_UPPER;
   assign pop    = sector_valid && sector_ready && ce;
   // bytes popped so far in this sector; cleared by the last one
   always_ff @(posedge mclk) begin
      if (!rst_n || (pop && sector_last)) begin
         pops <= 9'h000;
      end else if (pop) begin
         pops <= pops + 9'h001;
      end
   end
   property p_bad_sig;
      take && !sig_ok |=> cmd_reject;
   endproperty
   a_bad_sig: assert property (p_bad_sig) else $error("bad signature not rejected");
   property p_status_ans;
      take && sig_ok && cmd_features == FEAT_STATUS && !busy |=> status_valid && !cmd_reject;
   endproperty
   a_status_ans: assert property (p_status_ans) else $error("status query unanswered");
   property p_status_val;
      status_valid |-> {status_cyl_lo, status_cyl_hi} inside {16'hF42C, 16'h4FC2};
   endproperty
   a_status_val: assert property (p_status_val) else $error("status pair illegal");
   property p_thr_start;
      take && sig_ok && cmd_features == FEAT_READ_THR && !busy
         |=> busy ##1 (sector_valid && sector_data == 8'h04);
   endproperty
   a_thr_start: assert property (p_thr_start) else $error("sector did not start");
   property p_hold;
      sector_valid && !(sector_ready && ce)
         |=> sector_valid && $stable(sector_data) && $stable(sector_last);
   endproperty
   a_hold: assert property (p_hold) else $error("stalled byte changed");
   property p_count;
      pop |-> sector_last == (pops == 9'h1FF);
   endproperty
   a_count: assert property (p_count) else $error("last flag not on byte 511");
   property p_version;
      pop && pops < 9'h002 |-> sector_data == ((pops == 9'h000) ? 8'h04 : 8'h00);
   endproperty
   a_version: assert property (p_version) else $error("version word wrong");
   property p_end;
      pop && sector_last |=> !sector_valid ##[0:1] !busy;
   endproperty
   a_end: assert property (p_end) else $error("stream ran past one sector");
   property p_stream_rej;
      take && sector_valid |=> cmd_reject;
   endproperty
   a_stream_rej: assert property (p_stream_rej) else $error("command taken mid-sector");
   c_status: cover property (status_valid);
   c_last: cover property (pop && sector_last);
   c_reject: cover property (cmd_reject);
endmodule // sasb_checker

bind smart_attribute_sector_builder sasb_checker u_chk (.mclk, .rst_n, .ce, .cmd_valid,
   .cmd_code, .cmd_features, .cmd_cyl_lo, .cmd_cyl_hi, .cmd_drive_head, .cmd_reject, .busy,
   .status_valid, .status_cyl_lo, .status_cyl_hi, .sector_valid, .sector_data, .sector_last,
   .sector_ready);

//--- verif/sasb_host.sv
// host side model: takes the threshold sector and can stall
module sasb_host (
   // clock and control
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       ce,
   input wire logic       stall,
   // sector stream
   input wire logic       sector_valid,
   input wire logic [7:0] sector_data,
   input wire logic       sector_last,
   output logic           sector_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [512];
   int         cnt;
   int         last_at;
   logic [1:0] phase;
   // one stalled cycle in three exercises the skid buffer
   always_ff @(posedge mclk) begin
      phase <= (!rst_n || phase == 2'd2) ? 2'd0 : phase + 2'd1;
      sector_ready <= rst_n && !(stall && phase == 2'd1);
   end
   // keep each popped byte in arrival order
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt <= 0;
         last_at <= -1;
      end else if (sector_valid && sector_ready && ce && cnt < 512) begin
         mem[cnt] <= sector_data;
         cnt <= cnt + 1;
         if (sector_last) last_at <= cnt;
      end
   end
endmodule // sasb_host

//--- verif/smart_attribute_sector_builder_tb.sv
// self-checking bench for the attribute sector builder
module smart_attribute_sector_builder_tb
   import smart_attr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, cmd_valid = 1'b0, stall = 1'b0;
   logic erase_evt = 1'b0, read_evt = 1'b0, ecc_corr_evt = 1'b0;
   logic ecc_uncorr_evt = 1'b0, crc_evt = 1'b0;
   logic cmd_reject, busy, status_valid, sector_valid, sector_last, sector_ready;
   logic [7:0] cmd_code = 8'h00, cmd_features = 8'h00, cmd_cyl_lo = 8'h00;
   logic [7:0] cmd_cyl_hi = 8'h00, cmd_drive_head = 8'h00;
   logic [7:0] erase_thr = 8'h00, spare_thr = 8'h00, spare_value = 8'h64;
   logic [7:0] status_cyl_lo, status_cyl_hi, attr_byte, sector_data;
   logic [31:0] erase_budget = 32'h0000000A;
   logic [2:0]  attr_sel = 3'h0;
   logic [3:0]  attr_idx = 4'h0;
   int          fails = 0;
   int          compares = 0;

   smart_attribute_sector_builder u_dut (.mclk, .rst_n, .ce, .cmd_valid, .cmd_code,
      .cmd_features, .cmd_cyl_lo, .cmd_cyl_hi, .cmd_drive_head, .cmd_reject, .busy,
      .status_valid, .status_cyl_lo, .status_cyl_hi, .erase_evt, .read_evt, .ecc_corr_evt,
      .ecc_uncorr_evt, .crc_evt, .erase_budget, .erase_thr, .spare_thr, .spare_value,
      .attr_sel, .attr_idx, .attr_byte, .sector_valid, .sector_data, .sector_last,
      .sector_ready);
   sasb_host u_host (.mclk, .rst_n, .ce, .stall, .sector_valid, .sector_data, .sector_last,
      .sector_ready);

   // 25 MHz clock
   always #20 mclk = ~mclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one task-file command; returns once its answer is visible
   task automatic send(input logic [39:0] c);
      @(posedge mclk);
      {cmd_code, cmd_features, cmd_cyl_lo, cmd_cyl_hi, cmd_drive_head} <= c;
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      #1;
   endtask

   task automatic t_reject;
      logic [39:0] bad [5] = '{40'hB1DA4FC2E0, 40'hB0DA4EC2E0, 40'hB0DA4FC3E0,
                               40'hB0DA4FC2C0, 40'hB0D04FC2E0};
      foreach (bad[i]) begin
         send(bad[i]);
         chk({cmd_reject, status_valid, busy}, 3'b100);
      end
      chk({status_cyl_lo, status_cyl_hi}, 16'h4FC2);
   endtask

   // counted events, then every byte of every entry
   task automatic t_events;
      logic [7:0] ids [5]  = '{ID_ERASE, ID_ECC_TOTAL, ID_ECC_CORR, ID_READS, ID_CRC};
      logic [7:0] vals [5] = '{8'h46, FIXED_VALUE, FIXED_VALUE, FIXED_VALUE, FIXED_VALUE};
      logic [7:0] cnts [5] = '{8'h03, 8'h03, 8'h02, 8'h05, 8'h01};
      logic [7:0] e;
      for (int i = 0; i < 5; i++) begin
         @(posedge mclk);
         {erase_evt, read_evt, ecc_corr_evt, ecc_uncorr_evt, crc_evt} <=
            {i < 3, 1'b1, i < 2, i < 1, i < 1};
      end
      @(posedge mclk);
      {erase_evt, read_evt, ecc_corr_evt, ecc_uncorr_evt, crc_evt} <= 5'h00;
      // life estimate settles within about 101 cycles
      repeat (150) @(posedge mclk);
      for (int s = 0; s < 6; s++) begin
         for (int k = 0; k < 13; k++) begin
            @(posedge mclk);
            attr_sel <= 3'(s);
            attr_idx <= 4'(k);
            @(posedge mclk);
            #1;
            e = (s > 4 || k > 11) ? 8'h00 : (k == 0) ? ids[s] : (k == 1) ? FLAGS_ADVISORY[7:0]
                : (k == 3) ? vals[s] : (k == 4) ? cnts[s] : 8'h00;
            chk(attr_byte, e);
         end
      end
   endtask

   // status answer against erase and spare thresholds
   task automatic t_status;
      logic [39:0] cs [4] = '{40'h461064_4FC2, 40'h471064_F42C, 40'h006564_F42C,
                              40'h000000_4FC2};
      foreach (cs[i]) begin
         @(posedge mclk);
         {erase_thr, spare_thr, spare_value} <= cs[i][39:16];
         send(40'hB0DA4FC2E0);
         chk({status_valid, status_cyl_lo, status_cyl_hi}, {1'b1, cs[i][15:0]});
      end
   endtask

   // threshold sector with host stalls, a refused command and a frozen clock enable
   task automatic t_sector;
      logic [7:0] exp [512];
      logic [7:0] sum;
      exp = '{default: 8'h00};
      exp[0:3] = '{8'h04, 8'h00, ID_SPARE, 8'h21};
      exp[14:15] = '{ID_ERASE, 8'h5A};
      exp[26] = ID_ECC_TOTAL;
      exp[38] = ID_ECC_CORR;
      exp[50] = ID_READS;
      exp[62] = ID_CRC;
      sum = 8'h00;
      for (int i = 0; i < 511; i++) sum += exp[i];
      exp[511] = -sum;
      @(posedge mclk);
      {erase_thr, spare_thr, stall} <= {8'h5A, 8'h21, 1'b1};
      send(40'hB0D14FC2F0);
      chk(busy, 1'b1);
      repeat (4) @(posedge mclk);
      send(40'hB0DA4FC2E0);
      chk({cmd_reject, status_valid}, 2'b10);
      @(posedge mclk);
      ce <= 1'b0;
      repeat (3) @(posedge mclk);
      ce <= 1'b1;
      // look just after each edge, once the design's registers have settled
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
         @(posedge mclk);
         #1;
      end
      chk(busy, 1'b0);
      chk(u_host.cnt, 32'd512);
      chk(u_host.last_at, 32'd511);
      for (int i = 0; i < 512; i++) chk(u_host.mem[i], exp[i]);
   endtask

   task automatic complete_run;
      if (fails == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      t_reject;
      t_events;
      t_status;
      t_sector;
      complete_run;
   end

   // hang guard, well beyond the roughly 1100 cycles the tests need
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      complete_run;
   end
endmodule // smart_attribute_sector_builder_tb
